// ### rtl/rtba_consts.vh
// constants of the real-time bit allocation block
// assumes inclusion by bare name from each design file
`ifndef RTBA_CONSTS_VH
`define RTBA_CONSTS_VH

// parameter numbers on the service channel
`define RTBA_P_CTL2_SRC 16'h012F
`define RTBA_P_ST1_VAL 16'h0130
`define RTBA_P_ST1_SRC 16'h0131
`define RTBA_P_ST2_VAL 16'h0132
`define RTBA_P_ST2_SRC 16'h0133
`define RTBA_P_TRAVEL 16'h0143
`define RTBA_P_INPOS 16'h0150

// signal identifiers that may be allocated
`define RTBA_ID_NONE 16'h0000
`define RTBA_ID_INPOS 16'h0150
`define RTBA_ID_HOME 16'h0190
`define RTBA_ID_FBREF 16'h0193
`define RTBA_ID_S409 16'h0199
`define RTBA_ID_S410 16'h019A
`define RTBA_ID_S411 16'h019B
`define RTBA_ID_S412 16'h019C
`define RTBA_ID_PROBE1 16'h0195
`define RTBA_ID_PROBE2 16'h0196
`define RTBA_ID_AUX 16'h0BDE

// reset value of every allocation
`define RTBA_SRC_RST 16'h0000

// field positions and masks
`define RTBA_RTC2_POS 7
`define RTBA_RT1_MASK 16'h0040
`define RTBA_RT2_MASK 16'h0080
`define RTBA_DIAG2_MASK 16'h2000
`define RTBA_DIAG3_MASK 16'h0040

// service channel element carrying operating data
`define RTBA_ELEM_DATA 3'h7

// communication phases
`define RTBA_CP2 3'h2
`define RTBA_CP4 3'h4

// travel-range warning codes
`define RTBA_WARN_NONE 3'h0
`define RTBA_WARN_POS_A 3'h1
`define RTBA_WARN_POS_B 3'h2
`define RTBA_WARN_NEG_A 3'h3
`define RTBA_WARN_NEG_B 3'h4

// flash half period and clock rate
`define RTBA_FLASH_HALF_MS 250
`define RTBA_CLK_KHZ 50000

`endif

// ### rtl/rtba_select.v
// status source selector: maps an allocation identifier onto one signal
// assumes signals are already synchronous to the caller's clock
`timescale 1ns/1ps
`include "rtba_consts.vh"

module rtba_select (
    input wire [15:0] src_id_i,
    input wire [6:0] sig_i,
    output reg bit_o,
    output reg valid_o
);

    // identifier decode; the undefined one and any unknown one give low
    always @* begin
        bit_o = 1'b0;
        valid_o = 1'b1;
        case (src_id_i)
            `RTBA_ID_NONE: begin
                bit_o = 1'b0;
            end
            `RTBA_ID_INPOS: begin
                bit_o = sig_i[0];
            end
            `RTBA_ID_HOME: begin
                bit_o = sig_i[1];
            end
            `RTBA_ID_FBREF: begin
                bit_o = sig_i[2];
            end
            `RTBA_ID_S409: begin
                bit_o = sig_i[3];
            end
            `RTBA_ID_S410: begin
                bit_o = sig_i[4];
            end
            `RTBA_ID_S411: begin
                bit_o = sig_i[5];
            end
            `RTBA_ID_S412: begin
                bit_o = sig_i[6];
            end
            default: begin
                valid_o = 1'b0;
            end
        endcase
    end

endmodule // rtba_select

// ### rtl/rtba_core.v
// real-time bit allocation: control bit 2 routing, status bits 1 and 2,
// in-position and travel-range flags, parameter access by service channel
// assumes all inputs synchronous to clk_i and cyc_tick_i one pulse per cycle
`timescale 1ns/1ps
`include "rtba_consts.vh"

// How it works
// [R01] control bit 2 from bit 7, allocated
// [R02] master may toggle control bits each cycle
// [R03] status bit 1 goes to bit 6
// [R04] status bit 2 goes to bit 7
// [R05] both status bits refreshed each cycle in phase 4
// [R06] status allocation: binary identifiers, 0 undefined
// [R07] only 0,336,400,403,409-412 accepted
// [R08] master drops old meaning after write
// [R09] old allocation holds until busy rises
// [R10] master uses new meaning after busy clears
// [R11] readable value of each status bit
// [R12] travel warning on target or limit switch
// [R13] travel warning mirrors class 2 bit 13
// [R14] distinct flashing codes per violated side
// [R15] in-position when error inside window
// [R16] in-position mirrors class 3 bit 6, selectable
// [R17] control allocation: 0, probes, or 3038
// [R18] new control meaning live before busy clears
// [R19] undefined status allocation drives low
module rtba_core #(
    parameter CNT_W = 24,
    parameter FLASH_HALF_CYC = `RTBA_FLASH_HALF_MS * `RTBA_CLK_KHZ
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire cyc_tick_i,
    input wire [2:0] phase_i,
    input wire [15:0] mdt_ctrl_i,
    input wire [15:0] at_status_base_i,
    input wire [15:0] diag2_base_i,
    input wire [15:0] diag3_base_i,
    input wire control_source_selector_i,
    input wire [31:0] pos_cmd_i,
    input wire [31:0] pos_fb_i,
    input wire [31:0] position_window_param_i,
    input wire home_sw_i,
    input wire fb_ref_i,
    input wire [3:0] st_aux_i,
    input wire tgt_pos_i,
    input wire tgt_neg_i,
    input wire lim_pos_i,
    input wire lim_neg_i,
    input wire sc_req_i,
    input wire sc_wr_i,
    input wire [15:0] sc_idn_i,
    input wire [2:0] sc_elem_i,
    input wire [15:0] sc_wdata_i,
    output wire sc_busy_o,
    output wire sc_done_o,
    output wire sc_err_o,
    output wire [15:0] sc_rdata_o,
    output wire [15:0] at_status_o,
    output wire [15:0] diag2_o,
    output wire [15:0] diag3_o,
    output wire probe1_en_o,
    output wire probe2_en_o,
    output wire aux_ctrl_o,
    output wire [2:0] warn_code_o,
    output wire warn_flash_o
);

    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_DONE = 2'h2;
    localparam [CNT_W-1:0] FLASH_LAST = FLASH_HALF_CYC[CNT_W-1:0] - 1'b1;

    reg [1:0] state_reg;
    reg busy_reg;
    reg done_reg;
    reg err_reg;
    reg [15:0] rdata_reg;
    reg req_wr_reg;
    reg [15:0] req_idn_reg;
    reg [2:0] req_elem_reg;
    reg [15:0] req_wdata_reg;
    reg [15:0] ctl_src_reg;
    reg [15:0] st_src_reg [0:1];
    reg rtc2_reg;
    reg [15:0] at_status_reg;
    reg [15:0] diag2_reg;
    reg [15:0] diag3_reg;
    reg probe1_reg;
    reg probe2_reg;
    reg aux_reg;
    reg inpos_reg;
    reg travel_reg;
    reg [2:0] warn_reg;
    reg blink_reg;
    reg [CNT_W-1:0] flash_cnt_reg;
    reg [15:0] rd_mux;
    reg [2:0] warn_next;

    wire [1:0] rt_val;
    wire [6:0] st_sig;
    wire cand_valid;
    wire [32:0] pdiff;
    wire [32:0] pabs;
    wire inpos_now;
    wire travel_now;
    wire phase_wr_ok;
    wire is_st_src;
    wire st_idx;
    wire ctl_valid;
    wire mapped;
    wire writable;
    wire exec_err;

    // status signals offered for allocation
    assign st_sig = {st_aux_i, fb_ref_i, home_sw_i, inpos_reg};

    // [R06] [R07] [R19] per-bit source decode
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_rts
            rtba_select u_sel (
                .src_id_i(st_src_reg[gi]),
                .sig_i(st_sig),
                .bit_o(rt_val[gi]),
                .valid_o()
            );
        end
    endgenerate

    // [R07] candidate check for a status allocation write
    rtba_select u_cand (
        .src_id_i(req_wdata_reg),
        .sig_i(st_sig),
        .bit_o(),
        .valid_o(cand_valid)
    );

    // [R15] following error magnitude against the window
    assign pdiff = {pos_cmd_i[31], pos_cmd_i} - {pos_fb_i[31], pos_fb_i};
    assign pabs = pdiff[32] ? (33'h000000000 - pdiff) : pdiff;
    assign inpos_now = (pabs <= {1'b0, position_window_param_i});

    // [R12] target outside range or a limit switch active
    assign travel_now = tgt_pos_i | tgt_neg_i | lim_pos_i | lim_neg_i;

    // [R17] control identifier check against the selector
    assign ctl_valid = (req_wdata_reg == `RTBA_ID_NONE) ||
        (!control_source_selector_i &&
         ((req_wdata_reg == `RTBA_ID_PROBE1) ||
          (req_wdata_reg == `RTBA_ID_PROBE2))) ||
        (control_source_selector_i && (req_wdata_reg == `RTBA_ID_AUX));

    // request decode
    assign phase_wr_ok = (phase_i >= `RTBA_CP2) && (phase_i <= `RTBA_CP4);
    assign is_st_src = (req_idn_reg == `RTBA_P_ST1_SRC) ||
        (req_idn_reg == `RTBA_P_ST2_SRC);
    assign st_idx = (req_idn_reg == `RTBA_P_ST2_SRC);
    assign writable = is_st_src || (req_idn_reg == `RTBA_P_CTL2_SRC);
    assign mapped = writable || (req_idn_reg == `RTBA_P_ST1_VAL) ||
        (req_idn_reg == `RTBA_P_ST2_VAL) ||
        (req_idn_reg == `RTBA_P_TRAVEL) ||
        (req_idn_reg == `RTBA_P_INPOS);
    assign exec_err = (req_elem_reg != `RTBA_ELEM_DATA) || !mapped ||
        (req_wr_reg && (!writable || !phase_wr_ok ||
         (is_st_src && !cand_valid) ||
         (!is_st_src && !ctl_valid)));

    // [R11] read data for each parameter
    always @* begin
        rd_mux = 16'h0000;
        case (req_idn_reg)
            `RTBA_P_CTL2_SRC: begin
                rd_mux = ctl_src_reg;
            end
            `RTBA_P_ST1_SRC: begin
                rd_mux = st_src_reg[0];
            end
            `RTBA_P_ST2_SRC: begin
                rd_mux = st_src_reg[1];
            end
            `RTBA_P_ST1_VAL: begin
                rd_mux = {15'h0000, rt_val[0]};
            end
            `RTBA_P_ST2_VAL: begin
                rd_mux = {15'h0000, rt_val[1]};
            end
            `RTBA_P_TRAVEL: begin
                rd_mux = {15'h0000, travel_reg};
            end
            `RTBA_P_INPOS: begin
                rd_mux = {15'h0000, inpos_reg};
            end
            default: begin
                rd_mux = 16'h0000;
            end
        endcase
    end

    // service channel handshake; busy frames every access
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            req_wr_reg <= 1'b0;
            req_idn_reg <= 16'h0000;
            req_elem_reg <= 3'h0;
            req_wdata_reg <= 16'h0000;
            ctl_src_reg <= `RTBA_SRC_RST;
            st_src_reg[0] <= `RTBA_SRC_RST;
            st_src_reg[1] <= `RTBA_SRC_RST;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // [R09] busy rises before any allocation changes
                    if (sc_req_i) begin
                        busy_reg <= 1'b1;
                        req_wr_reg <= sc_wr_i;
                        req_idn_reg <= sc_idn_i;
                        req_elem_reg <= sc_elem_i;
                        req_wdata_reg <= sc_wdata_i;
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    err_reg <= exec_err;
                    rdata_reg <= (exec_err || req_wr_reg) ? 16'h0000 : rd_mux;
                    // [R18] new control meaning applied while busy
                    if (!exec_err && req_wr_reg && !is_st_src) begin
                        ctl_src_reg <= req_wdata_reg;
                    end
                    // [R09] new status source applied while busy
                    if (!exec_err && req_wr_reg && is_st_src) begin
                        st_src_reg[st_idx] <= req_wdata_reg;
                    end
                    state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    // [R18] busy clears one cycle after the change
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    busy_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // [R01] [R02] control bit 2 sampled every communication cycle
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            rtc2_reg <= 1'b0;
        end else if (cyc_tick_i) begin
            rtc2_reg <= mdt_ctrl_i[`RTBA_RTC2_POS];
        end
    end

    // [R01] route control bit 2 to the allocated signal
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            probe1_reg <= 1'b0;
            probe2_reg <= 1'b0;
            aux_reg <= 1'b0;
        end else begin
            probe1_reg <= rtc2_reg && !control_source_selector_i &&
                (ctl_src_reg == `RTBA_ID_PROBE1);
            probe2_reg <= rtc2_reg && !control_source_selector_i &&
                (ctl_src_reg == `RTBA_ID_PROBE2);
            aux_reg <= rtc2_reg && control_source_selector_i &&
                (ctl_src_reg == `RTBA_ID_AUX);
        end
    end

    // [R05] status word rebuilt every cycle tick in phase 4
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            at_status_reg <= 16'h0000;
        end else if (cyc_tick_i) begin
            // [R03] [R04] status bits at positions 6 and 7
            if (phase_i == `RTBA_CP4) begin
                at_status_reg <= (at_status_base_i &
                    ~(`RTBA_RT1_MASK | `RTBA_RT2_MASK)) |
                    (rt_val[0] ? `RTBA_RT1_MASK : 16'h0000) |
                    (rt_val[1] ? `RTBA_RT2_MASK : 16'h0000);
            end else begin
                at_status_reg <= at_status_base_i &
                    ~(`RTBA_RT1_MASK | `RTBA_RT2_MASK);
            end
        end
    end

    // flags and diagnostic words, all taken on the same edge
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            inpos_reg <= 1'b0;
            travel_reg <= 1'b0;
            diag2_reg <= 16'h0000;
            diag3_reg <= 16'h0000;
        end else begin
            inpos_reg <= inpos_now;
            travel_reg <= travel_now;
            // [R13] travel flag mirrored in class 2 bit 13
            diag2_reg <= (diag2_base_i & ~`RTBA_DIAG2_MASK) |
                (travel_now ? `RTBA_DIAG2_MASK : 16'h0000);
            // [R16] in-position mirrored in class 3 bit 6
            diag3_reg <= (diag3_base_i & ~`RTBA_DIAG3_MASK) |
                (inpos_now ? `RTBA_DIAG3_MASK : 16'h0000);
        end
    end

    // [R14] warning code by side; positive side first, limit switch outranks target within a side
    always @* begin
        if (lim_pos_i) begin
            warn_next = `RTBA_WARN_POS_B;
        end else if (tgt_pos_i) begin
            warn_next = `RTBA_WARN_POS_A;
        end else if (lim_neg_i) begin
            warn_next = `RTBA_WARN_NEG_B;
        end else if (tgt_neg_i) begin
            warn_next = `RTBA_WARN_NEG_A;
        end else begin
            warn_next = `RTBA_WARN_NONE;
        end
    end

    // [R14] flash timer runs only while a warning stands
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            warn_reg <= `RTBA_WARN_NONE;
            blink_reg <= 1'b0;
            flash_cnt_reg <= {CNT_W{1'b0}};
        end else begin
            warn_reg <= warn_next;
            if (warn_next == `RTBA_WARN_NONE) begin
                blink_reg <= 1'b0;
                flash_cnt_reg <= {CNT_W{1'b0}};
            end else if (flash_cnt_reg == FLASH_LAST) begin
                blink_reg <= !blink_reg;
                flash_cnt_reg <= {CNT_W{1'b0}};
            end else begin
                flash_cnt_reg <= flash_cnt_reg + 1'b1;
            end
        end
    end

    // outputs straight from flip-flops
    assign sc_busy_o = busy_reg;
    assign sc_done_o = done_reg;
    assign sc_err_o = err_reg;
    assign sc_rdata_o = rdata_reg;
    assign at_status_o = at_status_reg;
    assign diag2_o = diag2_reg;
    assign diag3_o = diag3_reg;
    assign probe1_en_o = probe1_reg;
    assign probe2_en_o = probe2_reg;
    assign aux_ctrl_o = aux_reg;
    assign warn_code_o = warn_reg;
    assign warn_flash_o = blink_reg;

endmodule // rtba_core

// ### dv/rtba_core_properties.sv
// checker: service channel timing, status word and flag relations
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "rtba_consts.vh"
module rtba_core_properties (
    input wire clk_i,
    input wire rst_n_i,
    input wire cyc_tick_i,
    input wire [2:0] phase_i,
    input wire [15:0] at_status_base_i,
    input wire tgt_pos_i,
    input wire tgt_neg_i,
    input wire lim_pos_i,
    input wire lim_neg_i,
    input wire sc_req_i,
    input wire sc_busy_o,
    input wire sc_done_o,
    input wire [15:0] at_status_o,
    input wire [15:0] diag2_o,
    input wire probe1_en_o,
    input wire probe2_en_o,
    input wire aux_ctrl_o,
    input wire [2:0] warn_code_o
);
    // any side out of travel range
    wire any_rng = tgt_pos_i | tgt_neg_i | lim_pos_i | lim_neg_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    take_req_a: assert property (sc_req_i && !sc_busy_o |=> sc_busy_o)
        else $error("request not taken");
    busy_len_a: assert property ($rose(sc_busy_o) |=>
        sc_busy_o ##1 (!sc_busy_o && sc_done_o))
        else $error("busy length wrong");
    done_once_a: assert property (sc_done_o |=> !sc_done_o)
        else $error("done longer than one cycle");
    status_hold_a: assert property (!cyc_tick_i |=> $stable(at_status_o))
        else $error("status word changed off tick");
    phase_mask_a: assert property (cyc_tick_i && phase_i != `RTBA_CP4 |=>
        at_status_o[7:6] == 2'h0)
        else $error("status bits set outside phase 4");
    base_pass_a: assert property (cyc_tick_i |=>
        (at_status_o & 16'hFF3F) == ($past(at_status_base_i) & 16'hFF3F))
        else $error("status word base bits wrong");
    travel_flag_a: assert property (1'h1 |=> diag2_o[13] == $past(any_rng))
        else $error("travel flag differs from inputs");
    pos_prio_a: assert property (lim_pos_i |-> ##[1:2] warn_code_o == `RTBA_WARN_POS_B)
        else $error("positive limit code wrong");
    neg_code_a: assert property (lim_neg_i && !lim_pos_i && !tgt_pos_i
        |-> ##[1:2] warn_code_o == `RTBA_WARN_NEG_B)
        else $error("negative limit code wrong");
    route_one_a: assert property (probe1_en_o |-> !probe2_en_o && !aux_ctrl_o)
        else $error("control bit routed twice");
    cover property (sc_done_o);
    cover property (cyc_tick_i && phase_i == `RTBA_CP4 ##1 at_status_o[6]);
    cover property (probe1_en_o);
endmodule // rtba_core_properties

bind rtba_core rtba_core_properties u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cyc_tick_i(cyc_tick_i), .phase_i(phase_i), .at_status_base_i(at_status_base_i),
    .tgt_pos_i(tgt_pos_i), .tgt_neg_i(tgt_neg_i), .lim_pos_i(lim_pos_i),
    .lim_neg_i(lim_neg_i), .sc_req_i(sc_req_i), .sc_busy_o(sc_busy_o),
    .sc_done_o(sc_done_o), .at_status_o(at_status_o), .diag2_o(diag2_o),
    .probe1_en_o(probe1_en_o), .probe2_en_o(probe2_en_o), .aux_ctrl_o(aux_ctrl_o),
    .warn_code_o(warn_code_o));

// ### dv/rtba_master_model.sv
// master model: cycle tick and control word carrying two control bits
// assumes the core's clock and synchronous reset
`timescale 1ns/1ps
module rtba_master_model #(
    parameter TICK_N = 4
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [1:0] rtc_i,
    output reg cyc_tick_o,
    output reg [15:0] mdt_ctrl_o
);
    reg [3:0] cnt_reg;
    // control bits renewed every cycle, other bits keep changing
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 4'h0;
            cyc_tick_o <= 1'h0;
            mdt_ctrl_o <= 16'h0000;
        end else begin
            cyc_tick_o <= (cnt_reg == TICK_N - 1);
            cnt_reg <= (cnt_reg == TICK_N - 1) ? 4'h0 : cnt_reg + 4'h1;
            if (cnt_reg == TICK_N - 1)
                mdt_ctrl_o <= {~mdt_ctrl_o[15:8], rtc_i, ~mdt_ctrl_o[5:0]};
        end
    end
endmodule // rtba_master_model

// ### dv/rtba_core_bench.sv
// bench: parameter access, status word, control routing and flags
// assumes master model makes ticks; bench drives phase and service channel
`timescale 1ns/1ps
`include "rtba_consts.vh"
module rtba_core_bench;
    localparam [15:0] BASE = 16'h5AFF;
    localparam [15:0] BASE2 = 16'h0481;
    localparam [15:0] BASE3 = 16'h1200;
    localparam [127:0] OKS = {16'h0000, 16'h0150, 16'h0190, 16'h0193,
        16'h0199, 16'h019A, 16'h019B, 16'h019C};
    localparam [63:0] BADS = {16'h0151, 16'h0191, 16'h0195, 16'h0001};
    reg clk_i = 1'h0;
    reg rst_n_i = 1'h0;
    reg [2:0] phase_i = 3'h4;
    reg sel_i = 1'h0;
    reg [31:0] pos_cmd_i = 32'h0;
    reg [31:0] pos_fb_i = 32'h0;
    reg home_sw_i = 1'h0;
    reg fb_ref_i = 1'h0;
    reg [3:0] st_aux_i = 4'h0;
    reg [3:0] rng_i = 4'h0;
    reg sc_req_i = 1'h0;
    reg sc_wr_i = 1'h0;
    reg [15:0] sc_idn_i = 16'h0;
    reg [2:0] sc_elem_i = 3'h7;
    reg [15:0] sc_wdata_i = 16'h0;
    reg [1:0] rtc = 2'h0;
    reg f;
    integer errors;
    integer total_checks;
    integer i;
    wire tick, busy, done, err, p1, p2, aux, fl;
    wire [15:0] mdt, rd, st, d2, d3;
    wire [2:0] wc;
    // 50 MHz clock
    always #10 clk_i = ~clk_i;
    rtba_master_model u_mst (.clk_i(clk_i), .rst_n_i(rst_n_i), .rtc_i(rtc),
        .cyc_tick_o(tick), .mdt_ctrl_o(mdt));
    rtba_core #(.FLASH_HALF_CYC(4)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .cyc_tick_i(tick), .phase_i(phase_i), .mdt_ctrl_i(mdt), .at_status_base_i(BASE),
        .diag2_base_i(BASE2), .diag3_base_i(BASE3), .control_source_selector_i(sel_i),
        .pos_cmd_i(pos_cmd_i), .pos_fb_i(pos_fb_i), .position_window_param_i(32'hA),
        .home_sw_i(home_sw_i), .fb_ref_i(fb_ref_i), .st_aux_i(st_aux_i),
        .tgt_pos_i(rng_i[0]), .tgt_neg_i(rng_i[2]), .lim_pos_i(rng_i[1]),
        .lim_neg_i(rng_i[3]), .sc_req_i(sc_req_i), .sc_wr_i(sc_wr_i),
        .sc_idn_i(sc_idn_i), .sc_elem_i(sc_elem_i), .sc_wdata_i(sc_wdata_i),
        .sc_busy_o(busy), .sc_done_o(done), .sc_err_o(err), .sc_rdata_o(rd),
        .at_status_o(st), .diag2_o(d2), .diag3_o(d3), .probe1_en_o(p1),
        .probe2_en_o(p2), .aux_ctrl_o(aux), .warn_code_o(wc), .warn_flash_o(fl));
    task chk(input [8*4:1] nm, input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
    // one service channel access, judged at its done pulse
    task sc(input w, input [15:0] idn, input [2:0] el, input [15:0] wd, input e_err,
        input [15:0] e_rd);
        integer n;
        begin
            @(posedge clk_i);
            sc_req_i <= 1'h1;
            sc_wr_i <= w;
            sc_idn_i <= idn;
            sc_elem_i <= el;
            sc_wdata_i <= wd;
            @(posedge clk_i);
            sc_req_i <= 1'h0;
            n = 1;
            @(negedge clk_i);
            chk("bsy", {15'h0, busy}, 16'h1);
            while (done !== 1'h1 && n < 8) begin
                @(negedge clk_i);
                n = n + 1;
            end
            chk("lat", n[15:0], 16'h3);
            chk("bsy", {15'h0, busy}, 16'h0);
            chk("err", {15'h0, err}, {15'h0, e_err});
            chk("rd", rd, e_rd);
        end
    endtask
    function [15:0] exp_st(input b2, input b1);
        exp_st = (BASE & 16'hFF3F) | {8'h0, b2, b1, 6'h0};
    endfunction
    task t_regs;
        begin
            sc(1'h0, `RTBA_P_CTL2_SRC, 3'h7, 16'h0, 1'h0, 16'h0);
            sc(1'h0, `RTBA_P_ST1_SRC, 3'h7, 16'h0, 1'h0, 16'h0);
            sc(1'h0, `RTBA_P_ST2_SRC, 3'h7, 16'h0, 1'h0, 16'h0);
            sc(1'h1, `RTBA_P_ST2_VAL, 3'h7, 16'h1, 1'h1, 16'h0);
            sc(1'h1, 16'h0200, 3'h7, 16'h0, 1'h1, 16'h0);
            sc(1'h1, `RTBA_P_ST1_SRC, 3'h3, 16'h0150, 1'h1, 16'h0);
            @(posedge clk_i) phase_i <= 3'h0;
            sc(1'h1, `RTBA_P_ST1_SRC, 3'h7, 16'h0150, 1'h1, 16'h0);
            @(posedge clk_i) phase_i <= 3'h4;
            $display("regs done");
        end
    endtask
    task t_alloc;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                sc(1'h1, `RTBA_P_ST2_SRC, 3'h7, OKS[i*16 +: 16], 1'h0, 16'h0);
                sc(1'h0, `RTBA_P_ST2_SRC, 3'h7, 16'h0, 1'h0, OKS[i*16 +: 16]);
            end
            for (i = 0; i < 4; i = i + 1) begin
                sc(1'h1, `RTBA_P_ST2_SRC, 3'h7, BADS[i*16 +: 16], 1'h1, 16'h0);
                sc(1'h0, `RTBA_P_ST2_SRC, 3'h7, 16'h0, 1'h0, 16'h0000);
            end
            $display("alloc done");
        end
    endtask
    task t_status;
        begin
            @(posedge clk_i) home_sw_i <= 1'h1;
            st_aux_i <= 4'h8;
            // status word read only after busy has cleared
            sc(1'h1, `RTBA_P_ST1_SRC, 3'h7, 16'h0190, 1'h0, 16'h0);
            sc(1'h1, `RTBA_P_ST2_SRC, 3'h7, 16'h0000, 1'h0, 16'h0);
            cyc(12);
            chk("st", st, exp_st(1'h0, 1'h1));
            sc(1'h1, `RTBA_P_ST2_SRC, 3'h7, 16'h019C, 1'h0, 16'h0);
            cyc(12);
            chk("st", st, exp_st(1'h1, 1'h1));
            sc(1'h0, `RTBA_P_ST2_VAL, 3'h7, 16'h0, 1'h0, 16'h1);
            sc(1'h0, `RTBA_P_ST1_VAL, 3'h7, 16'h0, 1'h0, 16'h1);
            @(posedge clk_i) phase_i <= 3'h2;
            cyc(12);
            chk("st", st, exp_st(1'h0, 1'h0));
            @(posedge clk_i) phase_i <= 3'h4;
            $display("status done");
        end
    endtask
    task t_ctrl;
        begin
            @(posedge clk_i) rtc <= 2'h2;
            sc(1'h1, `RTBA_P_CTL2_SRC, 3'h7, 16'h0195, 1'h0, 16'h0);
            cyc(12);
            chk("ctl", {13'h0, p1, p2, aux}, 16'h4);
            sc(1'h1, `RTBA_P_CTL2_SRC, 3'h7, 16'h0196, 1'h0, 16'h0);
            cyc(8);
            chk("ctl", {13'h0, p1, p2, aux}, 16'h2);
            sc(1'h1, `RTBA_P_CTL2_SRC, 3'h7, 16'h0BDE, 1'h1, 16'h0);
            @(posedge clk_i) rtc <= 2'h0;
            cyc(12);
            chk("ctl", {13'h0, p1, p2, aux}, 16'h0);
            @(posedge clk_i) sel_i <= 1'h1;
            rtc <= 2'h2;
            sc(1'h1, `RTBA_P_CTL2_SRC, 3'h7, 16'h0BDE, 1'h0, 16'h0);
            cyc(12);
            chk("ctl", {13'h0, p1, p2, aux}, 16'h1);
            sc(1'h1, `RTBA_P_CTL2_SRC, 3'h7, 16'h0195, 1'h1, 16'h0);
            $display("ctrl done");
        end
    endtask
    task t_flags;
        begin
            @(posedge clk_i) pos_cmd_i <= 32'h3E8;
            pos_fb_i <= 32'h3E3;
            sc(1'h1, `RTBA_P_ST1_SRC, 3'h7, 16'h0150, 1'h0, 16'h0);
            cyc(12);
            chk("d3", d3, BASE3 | 16'h0040);
            chk("st", st & 16'h0040, 16'h0040);
            @(posedge clk_i) pos_fb_i <= 32'h384;
            cyc(12);
            chk("d3", d3, BASE3);
            chk("st", st & 16'h0040, 16'h0000);
            for (i = 0; i < 4; i = i + 1) begin
                @(posedge clk_i) rng_i <= 4'h1 << i;
                cyc(3);
                chk("wc", {13'h0, wc}, i[15:0] + 16'h1);
                chk("d2", d2, BASE2 | 16'h2000);
                sc(1'h0, `RTBA_P_TRAVEL, 3'h7, 16'h0, 1'h0, 16'h1);
                f = fl;
                cyc(4);
                chk("fl", {15'h0, fl}, {15'h0, ~f});
            end
            @(posedge clk_i) rng_i <= 4'h0;
            cyc(3);
            chk("d2", d2, BASE2);
            $display("flags done");
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        errors = 0;
        total_checks = 0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'h1;
        t_regs;
        t_alloc;
        t_status;
        t_ctrl;
        t_flags;
        finish_test;
    end
    // watchdog
    initial begin
        #400000;
        errors = errors + 1;
        finish_test;
    end
endmodule // rtba_core_bench
